// >>> verilog/pfs_pkg.sv
// Package for the power fault status bank: command codes, bit positions, reset values.
// Assumes a core that decodes bus transactions into command reads and writes.
package pfs_pkg;

  localparam int         NUM_PAGES       = 2;

  // Command codes of the status reads
  localparam logic [7:0] CMD_STATUS_BYTE = 8'h78;
  localparam logic [7:0] CMD_SUMMARY     = 8'h79;
  localparam logic [7:0] CMD_OUT_VOLTAGE = 8'h7a;
  localparam logic [7:0] CMD_OUT_CURRENT = 8'h7b;
  localparam logic [7:0] CMD_INPUT       = 8'h7c;

  // Reset values
  localparam logic [15:0] SUMMARY_RESET = 16'h0000;
  localparam logic [7:0]  DETAIL_RESET  = 8'h00;

  // Summary word bit positions
  localparam int SW_OUT_VOLTAGE  = 15;
  localparam int SW_OUT_CURRENT  = 14;
  localparam int SW_INPUT        = 13;
  localparam int SW_VENDOR       = 12;
  localparam int SW_PGOOD_N      = 11;
  localparam int SW_RSVD_HI      = 10;
  localparam int SW_OTHER        = 9;
  localparam int SW_RSVD_LO      = 8;
  localparam int SW_BUSY         = 7;
  localparam int SW_OFF          = 6;
  localparam int SW_OUT_OV_FAULT = 5;
  localparam int SW_OUT_OC_FAULT = 4;
  localparam int SW_IN_UV_FAULT  = 3;
  localparam int SW_TEMPERATURE  = 2;
  localparam int SW_COMM         = 1;
  localparam int SW_NONE_ABOVE   = 0;

  // Detail register bit positions
  localparam int OV_OV_FAULT = 7;
  localparam int OV_UV_FAULT = 4;
  localparam int OC_OC_FAULT = 7;
  localparam int OC_UC_FAULT = 4;
  localparam int IN_OV_FAULT = 7;
  localparam int IN_OV_WARN  = 6;
  localparam int IN_UV_WARN  = 5;
  localparam int IN_UV_FAULT = 4;

  // Answer lengths in bytes
  localparam logic [1:0] LEN_ONE  = 2'h1;
  localparam logic [1:0] LEN_TWO  = 2'h2;
  localparam logic [1:0] LEN_NONE = 2'h0;

  // Byte count of a status command, zero when the command is not served here
  function automatic logic [1:0] pfs_cmd_len(input logic [7:0] cmd);
    if (cmd == CMD_SUMMARY) begin
      return LEN_TWO;
    end else if (cmd == CMD_STATUS_BYTE || cmd == CMD_OUT_VOLTAGE ||
                 cmd == CMD_OUT_CURRENT || cmd == CMD_INPUT) begin
      return LEN_ONE;
    end
    return LEN_NONE;
  endfunction

endpackage

// >>> verilog/pfs_sticky.sv
// Sticky flag bank: a set latches a flag until the clear pulse.
// Assumes set and clear are synchronous to clk_sys_i.
`timescale 1ns/100ps
module pfs_sticky #(
  parameter int W = 8
) (
  input  wire logic         clk_sys_i,
  input  wire logic         rst_b_i,
  input  wire logic [W-1:0] set_i,
  input  wire logic         clr_i,
  output logic      [W-1:0] flags_o
);

  // A set in the clearing cycle survives the clear
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      flags_o <= '0;
    end else begin
      flags_o <= (flags_o & ~{W{clr_i}}) | set_i;
    end
  end

endmodule

// >>> verilog/pfs_summary_word.sv
// Builds one page's registered summary word from its detail bytes and live levels.
// Assumes all inputs are synchronous to clk_sys_i.
`timescale 1ns/100ps
module pfs_summary_word (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_b_i,
  input  wire logic [7:0]  out_voltage_i,
  input  wire logic [7:0]  out_current_i,
  input  wire logic [7:0]  input_detail_i,
  input  wire logic        temp_any_i,
  input  wire logic        comm_any_i,
  input  wire logic        vendor_any_i,
  input  wire logic        busy_i,
  input  wire logic        power_good_i,
  input  wire logic        output_on_i,
  output logic      [15:0] word_o
);

  logic [15:0] next_word;

  always_comb begin
    next_word                               = pfs_pkg::SUMMARY_RESET;
    next_word[pfs_pkg::SW_OUT_VOLTAGE]      = |out_voltage_i;
    next_word[pfs_pkg::SW_OUT_CURRENT]      = |out_current_i;
    next_word[pfs_pkg::SW_INPUT]            = |input_detail_i;
    next_word[pfs_pkg::SW_VENDOR]           = vendor_any_i;
    next_word[pfs_pkg::SW_PGOOD_N]          = !power_good_i;
    next_word[pfs_pkg::SW_OTHER]            = |{out_voltage_i, out_current_i,
                                                input_detail_i, temp_any_i,
                                                comm_any_i, vendor_any_i};
    next_word[pfs_pkg::SW_BUSY]             = busy_i;
    next_word[pfs_pkg::SW_OFF]              = !output_on_i;
    next_word[pfs_pkg::SW_OUT_OV_FAULT]     = out_voltage_i[pfs_pkg::OV_OV_FAULT];
    next_word[pfs_pkg::SW_OUT_OC_FAULT]     = out_current_i[pfs_pkg::OC_OC_FAULT];
    next_word[pfs_pkg::SW_IN_UV_FAULT]      = input_detail_i[pfs_pkg::IN_UV_FAULT];
    next_word[pfs_pkg::SW_TEMPERATURE]      = temp_any_i;
    next_word[pfs_pkg::SW_COMM]             = comm_any_i;
    // Conditions whose source shows only in the high byte
    next_word[pfs_pkg::SW_NONE_ABOVE]       = out_voltage_i[pfs_pkg::OV_UV_FAULT] |
                                              out_current_i[pfs_pkg::OC_UC_FAULT] |
                                              input_detail_i[pfs_pkg::IN_OV_FAULT] |
                                              input_detail_i[pfs_pkg::IN_OV_WARN] |
                                              input_detail_i[pfs_pkg::IN_UV_WARN] |
                                              vendor_any_i;
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      word_o <= pfs_pkg::SUMMARY_RESET;
    end else begin
      word_o <= next_word;
    end
  end

endmodule

// >>> verilog/pfs_status_bank.sv
// Power fault status bank: paged summary word and the three detail registers,
// served to the command decoder as read-only status commands.
// Assumes the bus front end presents decoded commands synchronous to clk_sys_i
// and that the fault detectors outside pulse or hold their inputs high.
`timescale 1ns/100ps
module pfs_status_bank (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_b_i,
  // Command port
  input  wire logic        rd_req_i,
  input  wire logic        wr_req_i,
  input  wire logic [7:0]  cmd_i,
  input  wire logic        page_i,
  input  wire logic        clear_faults_i,
  // Per-channel fault sources
  input  wire logic [1:0]  output_overvoltage_fault_i,
  input  wire logic [1:0]  output_undervoltage_fault_i,
  input  wire logic [1:0]  output_overcurrent_fault_i,
  input  wire logic [1:0]  output_undercurrent_fault_i,
  input  wire logic [1:0]  temp_detail_any_i,
  input  wire logic [1:0]  power_good_i,
  input  wire logic [1:0]  output_on_i,
  // Global fault sources
  input  wire logic        input_overvoltage_fault_i,
  input  wire logic        input_overvoltage_warning_i,
  input  wire logic        input_undervoltage_warning_i,
  input  wire logic        input_undervoltage_fault_i,
  input  wire logic        busy_fault_i,
  input  wire logic        comm_detail_register_any_i,
  input  wire logic        vendor_detail_register_any_i,
  // Answer
  output logic             rd_valid_o,
  output logic [15:0]      rd_data_o,
  output logic [1:0]       rd_bytes_o,
  output logic             rd_unsupported_o,
  output logic             wr_refused_o
);

  logic [7:0]  output_voltage_status [pfs_pkg::NUM_PAGES];
  logic [7:0]  output_current_status [pfs_pkg::NUM_PAGES];
  logic [15:0] fault_summary_word    [pfs_pkg::NUM_PAGES];
  logic [7:0]  input_supply_status;
  logic [0:0]  busy_flag;
  logic [15:0] next_rd_data;
  logic [1:0]  next_rd_bytes;

  // Detail registers, one copy per page for the paged ones
  for (genvar ch = 0; ch < pfs_pkg::NUM_PAGES; ch++) begin : g_page
    logic [7:0] ov_set;
    logic [7:0] oc_set;

    always_comb begin
      ov_set                       = pfs_pkg::DETAIL_RESET;
      ov_set[pfs_pkg::OV_OV_FAULT] = output_overvoltage_fault_i[ch];
      ov_set[pfs_pkg::OV_UV_FAULT] = output_undervoltage_fault_i[ch];
      oc_set                       = pfs_pkg::DETAIL_RESET;
      oc_set[pfs_pkg::OC_OC_FAULT] = output_overcurrent_fault_i[ch];
      oc_set[pfs_pkg::OC_UC_FAULT] = output_undercurrent_fault_i[ch];
    end

    pfs_sticky #(.W(8)) u_out_voltage (
      .clk_sys_i (clk_sys_i),
      .rst_b_i   (rst_b_i),
      .set_i     (ov_set),
      .clr_i     (clear_faults_i),
      .flags_o   (output_voltage_status[ch])
    );

    pfs_sticky #(.W(8)) u_out_current (
      .clk_sys_i (clk_sys_i),
      .rst_b_i   (rst_b_i),
      .set_i     (oc_set),
      .clr_i     (clear_faults_i),
      .flags_o   (output_current_status[ch])
    );

    // Summary bits follow the details one register stage later, so they clear one cycle after them
    pfs_summary_word u_summary (
      .clk_sys_i      (clk_sys_i),
      .rst_b_i        (rst_b_i),
      .out_voltage_i  (output_voltage_status[ch]),
      .out_current_i  (output_current_status[ch]),
      .input_detail_i (input_supply_status),
      .temp_any_i     (temp_detail_any_i[ch]),
      .comm_any_i     (comm_detail_register_any_i),
      .vendor_any_i   (vendor_detail_register_any_i),
      .busy_i         (busy_flag[0]),
      .power_good_i   (power_good_i[ch]),
      .output_on_i    (output_on_i[ch]),
      .word_o         (fault_summary_word[ch])
    );
  end

  // Shared by both channels
  pfs_sticky #(.W(8)) u_input (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .set_i     ({input_overvoltage_fault_i, input_overvoltage_warning_i,
                 input_undervoltage_warning_i, input_undervoltage_fault_i,
                 4'h0}),
    .clr_i     (clear_faults_i),
    .flags_o   (input_supply_status)
  );

  pfs_sticky #(.W(1)) u_busy (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .set_i     (busy_fault_i),
    .clr_i     (clear_faults_i),
    .flags_o   (busy_flag)
  );

  // Read multiplexer; the status byte is a view of the word, not a copy
  always_comb begin
    next_rd_data  = 16'h0000;
    next_rd_bytes = pfs_pkg::pfs_cmd_len(cmd_i);
    unique case (cmd_i)
      pfs_pkg::CMD_STATUS_BYTE: begin
        next_rd_data = {8'h00, fault_summary_word[page_i][7:0]};
      end
      pfs_pkg::CMD_SUMMARY: begin
        next_rd_data = fault_summary_word[page_i];
      end
      pfs_pkg::CMD_OUT_VOLTAGE: begin
        next_rd_data = {8'h00, output_voltage_status[page_i]};
      end
      pfs_pkg::CMD_OUT_CURRENT: begin
        next_rd_data = {8'h00, output_current_status[page_i]};
      end
      pfs_pkg::CMD_INPUT: begin
        next_rd_data = {8'h00, input_supply_status};
      end
      default: begin
        next_rd_data = 16'h0000;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_valid_o       <= 1'b0;
      rd_data_o        <= 16'h0000;
      rd_bytes_o       <= pfs_pkg::LEN_NONE;
      rd_unsupported_o <= 1'b0;
    end else begin
      rd_valid_o       <= rd_req_i && (next_rd_bytes != pfs_pkg::LEN_NONE);
      rd_data_o        <= rd_req_i ? next_rd_data : 16'h0000;
      rd_bytes_o       <= rd_req_i ? next_rd_bytes : pfs_pkg::LEN_NONE;
      rd_unsupported_o <= rd_req_i && (next_rd_bytes == pfs_pkg::LEN_NONE);
    end
  end

  // Writes reach no storage here; the answer only tells the decoder to flag it
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_refused_o <= 1'b0;
    end else begin
      wr_refused_o <= wr_req_i && (pfs_pkg::pfs_cmd_len(cmd_i) != pfs_pkg::LEN_NONE);
    end
  end

  // Checks
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_b_i);

  logic [15:0] sel_word;
  logic [7:0]  sel_output_voltage_summary;
  logic [7:0]  sel_output_current_summary;
  // Page-selected copies, as a read would return them
  assign sel_word = fault_summary_word[page_i];
  assign sel_output_voltage_summary = output_voltage_status[page_i];
  assign sel_output_current_summary = output_current_status[page_i];

  ov_fault_word_a: assert property (output_overvoltage_fault_i[0] ##1 !clear_faults_i
    |=> fault_summary_word[0][pfs_pkg::SW_OUT_OV_FAULT] &&
        fault_summary_word[0][pfs_pkg::SW_OUT_VOLTAGE] &&
        fault_summary_word[0][pfs_pkg::SW_OTHER])
    else $error("overvoltage fault missing from summary word");

  oc_fault_word_a: assert property (output_overcurrent_fault_i[1] ##1 !clear_faults_i
    |=> fault_summary_word[1][pfs_pkg::SW_OUT_OC_FAULT] &&
        fault_summary_word[1][pfs_pkg::SW_OUT_CURRENT])
    else $error("overcurrent fault missing from summary word");

  uv_fault_low_a: assert property (output_undervoltage_fault_i[1] ##1 !clear_faults_i
    |=> fault_summary_word[1][pfs_pkg::SW_NONE_ABOVE] &&
        fault_summary_word[1][pfs_pkg::SW_OUT_VOLTAGE] &&
        !fault_summary_word[1][pfs_pkg::SW_OUT_OV_FAULT] ||
        $past(output_overvoltage_fault_i[1], 2) || $past(output_voltage_status[1][7]))
    else $error("undervoltage fault not reported in bits 0 and 15");

  input_uv_both_a: assert property (input_undervoltage_fault_i ##1 !clear_faults_i
    |=> fault_summary_word[0][pfs_pkg::SW_IN_UV_FAULT] &&
        fault_summary_word[1][pfs_pkg::SW_IN_UV_FAULT] &&
        fault_summary_word[1][pfs_pkg::SW_INPUT])
    else $error("input undervoltage not shown on both pages");

  input_warn_bit_a: assert property (input_overvoltage_warning_i
    |=> input_supply_status[pfs_pkg::IN_OV_WARN])
    else $error("input overvoltage warning not latched");

  pgood_live_a: assert property (!power_good_i[0] |=>
    fault_summary_word[0][pfs_pkg::SW_PGOOD_N])
    else $error("power good low not reflected in bit 11");

  off_live_a: assert property (output_on_i[1] |=>
    !fault_summary_word[1][pfs_pkg::SW_OFF])
    else $error("off bit set while output is on");

  off_set_a: assert property (!output_on_i[1] |=> fault_summary_word[1][pfs_pkg::SW_OFF])
    else $error("off bit not set while output is off");

  busy_word_a: assert property (busy_fault_i ##1 !clear_faults_i
    |=> fault_summary_word[0][pfs_pkg::SW_BUSY] && fault_summary_word[1][pfs_pkg::SW_BUSY])
    else $error("busy fault not shown in bit 7");

  reserved_zero_a: assert property (fault_summary_word[page_i][pfs_pkg::SW_RSVD_HI] == 1'b0 &&
    fault_summary_word[page_i][pfs_pkg::SW_RSVD_LO] == 1'b0 &&
    output_voltage_status[page_i][3:0] == 4'h0 && output_voltage_status[page_i][6:5] == 2'h0 &&
    output_current_status[page_i][6:5] == 2'h0 && input_supply_status[3:0] == 4'h0)
    else $error("unused status bit set");

  byte_shares_word_a: assert property (rd_req_i && cmd_i == pfs_pkg::CMD_STATUS_BYTE
    |=> rd_valid_o && rd_bytes_o == pfs_pkg::LEN_ONE &&
        rd_data_o == {8'h00, $past(sel_word[7:0])})
    else $error("status byte differs from summary low byte");

  word_read_page_a: assert property (rd_req_i && cmd_i == pfs_pkg::CMD_SUMMARY
    |=> rd_valid_o && rd_bytes_o == pfs_pkg::LEN_TWO && rd_data_o == $past(sel_word))
    else $error("summary read returned wrong page");

  write_refused_a: assert property (wr_req_i && cmd_i == pfs_pkg::CMD_INPUT && !rd_req_i
    |=> wr_refused_o && !rd_valid_o)
    else $error("write to read-only status not refused");

  clear_details_a: assert property (clear_faults_i && !output_overvoltage_fault_i[0] &&
    !output_undervoltage_fault_i[0] |=> output_voltage_status[0] == 8'h00)
    else $error("clear did not empty output voltage detail");

  set_beats_clear_a: assert property (clear_faults_i && output_overcurrent_fault_i[0]
    |=> output_current_status[0][pfs_pkg::OC_OC_FAULT])
    else $error("event lost in clearing cycle");

  // Summary bits trail their sources by one register stage
  output_voltage_summary_word_or_a: assert property (
    fault_summary_word[1][pfs_pkg::SW_OUT_VOLTAGE] == $past(|output_voltage_status[1]))
    else $error("voltage summary bit differs from its detail register");

  output_current_summary_word_or_a: assert property (
    fault_summary_word[1][pfs_pkg::SW_OUT_CURRENT] == $past(|output_current_status[1]))
    else $error("current summary bit differs from its detail register");

  input_word_or_a: assert property (
    fault_summary_word[0][pfs_pkg::SW_INPUT] == $past(|input_supply_status))
    else $error("input summary bit differs from its detail register");

  input_global_a: assert property (
    fault_summary_word[0][pfs_pkg::SW_INPUT] == fault_summary_word[1][pfs_pkg::SW_INPUT] &&
    fault_summary_word[0][pfs_pkg::SW_IN_UV_FAULT] ==
    fault_summary_word[1][pfs_pkg::SW_IN_UV_FAULT])
    else $error("input bits differ between pages");

  other_input_a: assert property ((|input_supply_status) |=>
    fault_summary_word[0][pfs_pkg::SW_OTHER] && fault_summary_word[1][pfs_pkg::SW_OTHER])
    else $error("other bit missing for an input detail bit");

  vendor_bit_a: assert property (vendor_detail_register_any_i |=>
    fault_summary_word[1][pfs_pkg::SW_VENDOR] && fault_summary_word[1][pfs_pkg::SW_OTHER])
    else $error("vendor bit missing from summary word");

  temp_bit_a: assert property (temp_detail_any_i[0] |=>
    fault_summary_word[0][pfs_pkg::SW_TEMPERATURE] && fault_summary_word[0][pfs_pkg::SW_OTHER])
    else $error("temperature bit missing from summary word");

  comm_bit_a: assert property (comm_detail_register_any_i |=>
    fault_summary_word[0][pfs_pkg::SW_COMM] && fault_summary_word[1][pfs_pkg::SW_COMM])
    else $error("communication bit missing from summary word");

  source_shown_a: assert property (sel_word[pfs_pkg::SW_NONE_ABOVE] |->
    |sel_word[15:8])
    else $error("bit 0 set with no source in the high byte");

  pgood_clear_a: assert property (power_good_i[0] |=>
    !fault_summary_word[0][pfs_pkg::SW_PGOOD_N])
    else $error("bit 11 set while power is good");

  sticky_hold_a: assert property (
    output_voltage_status[1][pfs_pkg::OV_OV_FAULT] && !clear_faults_i
    |=> output_voltage_status[1][pfs_pkg::OV_OV_FAULT])
    else $error("latched overvoltage flag lost without a clear");

  clear_input_a: assert property (clear_faults_i && !input_overvoltage_fault_i &&
    !input_overvoltage_warning_i && !input_undervoltage_warning_i &&
    !input_undervoltage_fault_i |=> input_supply_status == 8'h00)
    else $error("clear did not empty input detail");

  // Read answers stand in the cycle after the request edge
  input_read_a: assert property (rd_req_i && cmd_i == pfs_pkg::CMD_INPUT
    |=> rd_valid_o && rd_data_o == {8'h00, $past(input_supply_status)})
    else $error("input detail read returned wrong value");

  output_voltage_summary_read_a: assert property (rd_req_i && cmd_i == pfs_pkg::CMD_OUT_VOLTAGE
    |=> rd_bytes_o == pfs_pkg::LEN_ONE && rd_data_o == {8'h00, $past(sel_output_voltage_summary)})
    else $error("voltage detail read returned wrong page");

  output_current_summary_read_a: assert property (rd_req_i && cmd_i == pfs_pkg::CMD_OUT_CURRENT
    |=> rd_bytes_o == pfs_pkg::LEN_ONE && rd_data_o == {8'h00, $past(sel_output_current_summary)})
    else $error("current detail read returned wrong page");

  ov_word_cov: cover property (output_overvoltage_fault_i[1] ##2
    rd_req_i && cmd_i == pfs_pkg::CMD_SUMMARY && page_i);
  byte_read_cov: cover property (rd_req_i && cmd_i == pfs_pkg::CMD_STATUS_BYTE ##1
    rd_data_o != 16'h0000);
  clear_race_cov: cover property (clear_faults_i && input_undervoltage_fault_i);
  unsupported_cov: cover property (rd_req_i ##1 rd_unsupported_o);

endmodule

// >>> tb/pfs_host_model.sv
// Host model: issues status reads and writes as one-cycle command pulses.
// Assumes the bank answers on the same edge that takes a request, and reads the answer 1 ns after it.
`timescale 1ns/100ps
module pfs_host_model (
  input  wire logic        clk_sys_i,
  input  wire logic        rd_valid_i,
  input  wire logic [15:0] rd_data_i,
  input  wire logic [1:0]  rd_bytes_i,
  input  wire logic        rd_unsupported_i,
  input  wire logic        wr_refused_i,
  output logic             rd_req_o,
  output logic             wr_req_o,
  output logic [7:0]       cmd_o,
  output logic             page_o
);
  initial begin
    rd_req_o = 1'b0;
    wr_req_o = 1'b0;
    cmd_o    = 8'h00;
    page_o   = 1'b0;
  end

  // Flags come back as {valid, unsupported, refused}
  task automatic access(input logic wr, input logic [7:0] cmd, input logic pg,
                        output logic [15:0] data, output logic [1:0] nbytes,
                        output logic [2:0] flags);
    @(posedge clk_sys_i);
    rd_req_o <= ~wr;
    wr_req_o <= wr;
    cmd_o    <= cmd;
    page_o   <= pg;
    @(posedge clk_sys_i);
    rd_req_o <= 1'b0;
    wr_req_o <= 1'b0;
    // Scramble the lines once taken, so a stale code cannot pass for a sample
    cmd_o    <= ~cmd;
    page_o   <= ~pg;
    #1;
    data   = rd_data_i;
    nbytes = rd_bytes_i;
    flags  = {rd_valid_i, rd_unsupported_i, wr_refused_i};
  endtask
endmodule

// >>> tb/pfs_status_bank_tb.sv
// Testbench for the power fault status bank: hand-written scenarios per behaviour.
// Assumes the host model in pfs_host_model.sv drives the command port.
`timescale 1ns/100ps
`define CHK(what, exp, got) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
      n_mismatch++; \
      $display("Error %s expected %h seen %h", what, exp, got); \
    end \
  end
module pfs_status_bank_tb;
  logic        clk_sys_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic        rd_req, wr_req, page, rd_valid, rd_unsup, wr_refused;
  logic [7:0]  cmd;
  logic [15:0] rd_data;
  logic [1:0]  rd_bytes;
  logic        clear_faults = 1'b0;
  logic [1:0]  ov_f = 2'h0, uv_f = 2'h0, oc_f = 2'h0, uc_f = 2'h0, temp = 2'h0;
  logic [1:0]  pgood = 2'h3, on = 2'h3;
  logic        in_ovf = 1'b0, in_ovw = 1'b0, in_uvw = 1'b0, in_uvf = 1'b0;
  logic        busy = 1'b0, comm = 1'b0, vendor = 1'b0;
  int          n_mismatch = 0;
  int          tests_run = 0;

  initial forever #2.5 clk_sys_i = ~clk_sys_i;

  pfs_host_model host_inst (.clk_sys_i(clk_sys_i), .rd_valid_i(rd_valid),
    .rd_data_i(rd_data), .rd_bytes_i(rd_bytes), .rd_unsupported_i(rd_unsup),
    .wr_refused_i(wr_refused), .rd_req_o(rd_req), .wr_req_o(wr_req), .cmd_o(cmd),
    .page_o(page));

  pfs_status_bank pfs_status_bank_inst (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
    .rd_req_i(rd_req), .wr_req_i(wr_req), .cmd_i(cmd), .page_i(page),
    .clear_faults_i(clear_faults), .output_overvoltage_fault_i(ov_f),
    .output_undervoltage_fault_i(uv_f), .output_overcurrent_fault_i(oc_f),
    .output_undercurrent_fault_i(uc_f), .temp_detail_any_i(temp), .power_good_i(pgood),
    .output_on_i(on), .input_overvoltage_fault_i(in_ovf),
    .input_overvoltage_warning_i(in_ovw), .input_undervoltage_warning_i(in_uvw),
    .input_undervoltage_fault_i(in_uvf), .busy_fault_i(busy),
    .comm_detail_register_any_i(comm), .vendor_detail_register_any_i(vendor),
    .rd_valid_o(rd_valid), .rd_data_o(rd_data), .rd_bytes_o(rd_bytes),
    .rd_unsupported_o(rd_unsup), .wr_refused_o(wr_refused));

  task automatic rd(input logic [7:0] c, input logic pg, input logic [15:0] exp);
    logic [15:0] d;
    logic [1:0]  b;
    logic [2:0]  f;
    logic        served;
    served = (c >= pfs_pkg::CMD_STATUS_BYTE) && (c <= pfs_pkg::CMD_INPUT);
    host_inst.access(1'b0, c, pg, d, b, f);
    `CHK("read data", exp, d)
    `CHK("read length", (c == pfs_pkg::CMD_SUMMARY) ? 2'h2 : {1'b0, served}, b)
    `CHK("read flags", served ? 3'h4 : 3'h2, f)
  endtask

  task automatic wr(input logic [7:0] c);
    logic [15:0] d;
    logic [1:0]  b;
    logic [2:0]  f;
    host_inst.access(1'b1, c, 1'b0, d, b, f);
    `CHK("write flags", ((c >= 8'h78) && (c <= 8'h7c)) ? 3'h1 : 3'h0, f)
  endtask

  // Source index: 0 ov, 1 uv, 2 oc, 3 uc, 4..7 input, 8 busy, 9 clear
  task automatic set_src(input int i, input logic ch, input logic v);
    case (i)
      0: ov_f[ch] <= v;
      1: uv_f[ch] <= v;
      2: oc_f[ch] <= v;
      3: uc_f[ch] <= v;
      4: in_ovf <= v;
      5: in_ovw <= v;
      6: in_uvw <= v;
      7: in_uvf <= v;
      8: busy <= v;
      default: clear_faults <= v;
    endcase
  endtask

  task automatic pulse(input int i, input logic ch);
    @(posedge clk_sys_i);
    set_src(i, ch, 1'b1);
    @(posedge clk_sys_i);
    set_src(i, ch, 1'b0);
    repeat (3) @(posedge clk_sys_i);
  endtask

  task automatic do_reset();
    @(posedge clk_sys_i);
    rst_b_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
  endtask

  task automatic t_reset_values();
    for (int pg = 0; pg < 2; pg++) begin
      for (int c = 8'h78; c <= 8'h7c; c++) begin
        rd(8'(c), 1'(pg), 16'h0000);
      end
    end
    rd(8'h7d, 1'b0, 16'h0000);
  endtask

  task automatic t_faults();
    logic [7:0]  c_t [9] = '{8'h7a, 8'h7a, 8'h7b, 8'h7b, 8'h7c, 8'h7c, 8'h7c, 8'h7c, 8'h78};
    logic [7:0]  d_t [9] = '{8'h80, 8'h10, 8'h80, 8'h10, 8'h80, 8'h40, 8'h20, 8'h10, 8'h80};
    logic [15:0] w_t [9] = '{16'h8220, 16'h8201, 16'h4210, 16'h4201, 16'h2201, 16'h2201,
                             16'h2201, 16'h2208, 16'h0080};
    logic        glb;
    for (int i = 0; i < 9; i++) begin
      glb = (i >= 4);
      pulse(i, 1'b1);
      rd(c_t[i], 1'b1, {8'h00, d_t[i]});
      rd(8'h79, 1'b1, w_t[i]);
      rd(8'h78, 1'b1, {8'h00, w_t[i][7:0]});
      rd(8'h79, 1'b0, glb ? w_t[i] : 16'h0000);
      wr(c_t[i]);
      rd(c_t[i], 1'b0, glb ? {8'h00, d_t[i]} : 16'h0000);
      pulse(9, 1'b0);
      rd(8'h79, 1'b1, 16'h0000);
    end
    // Events only on the clearing edge, so a lost set cannot come back later
    @(posedge clk_sys_i);
    ov_f[0]      <= 1'b1;
    oc_f[0]      <= 1'b1;
    clear_faults <= 1'b1;
    @(posedge clk_sys_i);
    ov_f[0]      <= 1'b0;
    oc_f[0]      <= 1'b0;
    clear_faults <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    rd(8'h7a, 1'b0, 16'h0080);
    rd(8'h7b, 1'b0, 16'h0080);
    pulse(9, 1'b0);
    rd(8'h79, 1'b0, 16'h0000);
  endtask

  task automatic t_live();
    logic [15:0] w_t [5] = '{16'h0800, 16'h0040, 16'h0204, 16'h0202, 16'h1201};
    for (int j = 0; j < 5; j++) begin
      @(posedge clk_sys_i);
      pgood[0] <= (j != 0);
      on       <= {2{j != 1}};
      temp[0]  <= (j == 2);
      comm     <= (j == 3);
      vendor   <= (j == 4);
      repeat (3) @(posedge clk_sys_i);
      rd(8'h79, 1'b0, w_t[j]);
      rd(8'h79, 1'b1, (j == 1 || j > 2) ? w_t[j] : 16'h0000);
    end
    @(posedge clk_sys_i);
    vendor <= 1'b0;
  endtask

  task automatic t_mid_reset();
    pulse(2, 1'b0);
    pulse(7, 1'b0);
    do_reset();
    rd(8'h79, 1'b0, 16'h0000);
    rd(8'h7c, 1'b0, 16'h0000);
    wr(8'h55);
  endtask

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Guard against a hung scenario
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    n_mismatch++;
    wrap_up();
  end

  initial begin
    do_reset();
    t_reset_values();
    t_faults();
    t_live();
    t_mid_reset();
    wrap_up();
  end
endmodule
